// File: pkg/tws_cfg.svh
// Register map, reset values and scaling constants for the transmit scale/template block
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH
`define TWS_CH0_BLK    5'h1f
`define TWS_OFF_SCALE  6'h07
`define TWS_OFF_CTRL   6'h08
`define TWS_OFF_SAMPLE 6'h09
`define TWS_SCALE_RST  6'h36
`define TWS_CTRL_RST   6'h00
`define TWS_SAMPLE_RST 7'h00
`define TWS_CTRL_EN    6
`define TWS_CTRL_DIR   5
`define TWS_TPL_LAST   5'h12
`define TWS_ARB_BIT    3
`define TWS_T1_NOM     11'sh036
`define TWS_E1_NOM     11'sh021
`define TWS_T1_STEP    11'sh002
`define TWS_E1_STEP    11'sh003
`define TWS_NOM_PCT    11'sh064
`define TWS_T1_MAX     11'sh078
`define TWS_E1_MAX     11'sh0c8
`endif

// File: pkg/tws_pkg.sv
// Shared types of the transmit scale/template block
package tws_pkg;
	typedef logic [5:0] tws_factor_t;
	typedef logic [6:0] tws_sample_t;
	typedef logic [4:0] tws_taddr_t;
	typedef logic [7:0] tws_gain_t;
endpackage

// File: rtl/tws_regs.sv
// Per-channel amplitude scaling registers and template RAM access behind Wishbone
`timescale 1ns/1ps
`include "tws_cfg.svh"

module tws_regs #(
	parameter int NCH    = 16,
	parameter int TDEPTH = 19
) (
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      resetn_i,
	// Wishbone slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [12:0]               adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// Per-channel mode inputs
	input  wire logic [NCH*4-1:0]          pulse_template_select_i,
	input  wire logic [NCH-1:0]            e1_mode_i,
	// Per-channel scaling outputs
	output logic      [NCH*6-1:0]          amplitude_factor_o,
	output logic      [NCH*8-1:0]          amplitude_gain_o,
	// Line driver template read port
	input  wire logic [3:0]                tpl_rd_ch_i,
	input  wire tws_pkg::tws_taddr_t       tpl_rd_addr_i,
	output tws_pkg::tws_sample_t           tpl_rd_data_o
);
	import tws_pkg::*;

	tws_factor_t scale_reg  [NCH];
	logic [6:0]  ctrl_reg   [NCH];
	tws_sample_t sample_reg [NCH];
	tws_sample_t tram       [NCH][TDEPTH];
	tws_gain_t   gain_reg   [NCH];
	tws_gain_t   gain_next  [NCH];
	logic        ack_reg;
	logic [31:0] dat_reg;
	tws_sample_t tpl_rd_reg;

	// Decode: printed offsets are word indices, byte address is four times that
	wire  [10:0] idx       = adr_i[12:2];
	wire  [4:0]  blk       = idx[10:6];
	wire  [5:0]  roff      = idx[5:0];
	wire         is_ch0    = (blk == `TWS_CH0_BLK);
	wire         blk_ok    = is_ch0 || (blk < 5'(NCH - 1));
	wire  [3:0]  ch        = is_ch0 ? 4'h0 : 4'(blk + 5'h01);
	wire         hit_scale = blk_ok && (roff == `TWS_OFF_SCALE);
	wire         hit_ctrl  = blk_ok && (roff == `TWS_OFF_CTRL);
	wire         hit_samp  = blk_ok && (roff == `TWS_OFF_SAMPLE);
	wire         req       = cyc_i && stb_i;
	// Writes take effect on the edge where the master sees ack
	wire         wr_fire   = req && we_i && ack_reg && sel_i[0];

	// Effect of the control write that arms a RAM access
	wire  [6:0]  ctrl_wdat = dat_i[6:0];
	wire  [4:0]  tw_addr   = ctrl_wdat[4:0];
	wire         arb_mode  = pulse_template_select_i[4*ch + `TWS_ARB_BIT];
	wire         addr_ok   = (tw_addr <= `TWS_TPL_LAST);
	wire         tram_wr   = wr_fire && hit_ctrl && arb_mode && ctrl_wdat[`TWS_CTRL_EN]
				&& !ctrl_wdat[`TWS_CTRL_DIR] && addr_ok;
	wire  [6:0]  cur_ctrl  = ctrl_reg[ch];
	wire         rd_mode   = arb_mode && cur_ctrl[`TWS_CTRL_EN] && cur_ctrl[`TWS_CTRL_DIR];
	wire         rd_ok     = cur_ctrl[4:0] <= `TWS_TPL_LAST;
	wire  [6:0]  ram_q     = rd_ok ? tram[ch][cur_ctrl[4:0]] : `TWS_SAMPLE_RST;
	// Read mode shows RAM contents, otherwise the held sample value
	wire  [6:0]  samp_view = rd_mode ? ram_q : sample_reg[ch];
	wire  [31:0] rd_val    = hit_scale ? {26'h0, scale_reg[ch]} :
				 hit_ctrl  ? {25'h0, cur_ctrl} :
				 hit_samp  ? {25'h0, samp_view} : 32'h0;

	assign ack_o         = ack_reg;
	assign dat_o         = dat_reg;
	assign tpl_rd_data_o = tpl_rd_reg;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= req && !ack_reg;
			dat_reg <= (req && !ack_reg && !we_i) ? rd_val : 32'h0;
		end
	end

	// Reserved addresses in the template RAM are never written
	always_ff @(posedge mclk_i) begin
		if (tram_wr)
			tram[ch][tw_addr] <= sample_reg[ch];
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i)
			tpl_rd_reg <= `TWS_SAMPLE_RST;
		else if (tpl_rd_addr_i <= `TWS_TPL_LAST)
			tpl_rd_reg <= tram[tpl_rd_ch_i][tpl_rd_addr_i];
		else
			tpl_rd_reg <= `TWS_SAMPLE_RST;
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gen_ch
			wire        sel_me = (ch == 4'(g));
			wire        e1     = e1_mode_i[g];
			wire signed [10:0] dlt = $signed({5'h00, scale_reg[g]}) - (e1 ? `TWS_E1_NOM : `TWS_T1_NOM);
			wire signed [10:0] stp = e1 ? `TWS_E1_STEP : `TWS_T1_STEP;
			wire signed [10:0] raw = `TWS_NOM_PCT + 11'(stp * dlt);
			wire signed [10:0] top = e1 ? `TWS_E1_MAX : `TWS_T1_MAX;
			// Codes below the floor mean zero output, never a negative gain
			assign gain_next[g] = (raw < 11'sh000) ? 8'h00 :
					      (raw > top) ? top[7:0] : raw[7:0];

			always_ff @(posedge mclk_i) begin
				if (!resetn_i) begin
					scale_reg[g]  <= `TWS_SCALE_RST;
					ctrl_reg[g]   <= {1'b0, `TWS_CTRL_RST};
					sample_reg[g] <= `TWS_SAMPLE_RST;
					gain_reg[g]   <= 8'h00;
				end else begin
					gain_reg[g] <= gain_next[g];
					if (wr_fire && sel_me && hit_scale)
						scale_reg[g] <= dat_i[5:0];
					if (wr_fire && sel_me && hit_ctrl)
						ctrl_reg[g] <= ctrl_wdat;
					if (wr_fire && sel_me && hit_samp)
						sample_reg[g] <= dat_i[6:0];
				end
			end

			assign amplitude_factor_o[6*g +: 6] = scale_reg[g];
			assign amplitude_gain_o[8*g +: 8]   = gain_reg[g];
		end
	endgenerate

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_scale_reset_val: assert property (disable iff (1'b0) !resetn_i |=> scale_reg[0] == `TWS_SCALE_RST)
		else $error("scale register not at reset value");
	a_scale_write_hold: assert property (wr_fire && hit_scale && ch == 4'h0 |=>
		scale_reg[0] == $past(dat_i[5:0]))
		else $error("channel 0 scale write lost");
	a_read_upper_zero: assert property (ack_o |-> dat_o[31:7] == 25'h0 && !(hit_scale && dat_o[6]))
		else $error("reserved read bits not zero");
	a_t1_nominal_gain: assert property (!e1_mode_i[0] && scale_reg[0] == 6'h36 |->
		gain_next[0] == 8'h64 ##1 amplitude_gain_o[7:0] == 8'h64)
		else $error("T1 nominal code not 100 percent");
	a_e1_nominal_gain: assert property (e1_mode_i[0] && scale_reg[0] == 6'h21 |-> gain_next[0] == 8'h64)
		else $error("E1 nominal code not 100 percent");
	a_t1_gain_range: assert property (!e1_mode_i[0] |-> gain_next[0] <= 8'h78)
		else $error("T1 gain above plus 20 percent");
	a_e1_gain_range: assert property (e1_mode_i[0] && scale_reg[0] == 6'h3f |-> gain_next[0] == 8'hbe)
		else $error("E1 top code gain wrong");
	a_tram_store: assert property (tram_wr |=> tram[$past(ch)][$past(tw_addr)] == $past(sample_reg[ch]))
		else $error("template sample not stored");
	a_tram_addr_ok: assert property (tram_wr |-> tw_addr <= 5'h12 && arb_mode)
		else $error("template write outside valid range");
	a_sample_hold: assert property (!(wr_fire && hit_samp && ch == 4'h0) |=> $stable(sample_reg[0]))
		else $error("sample register changed without a write");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	// Bus handshake: fixed one-cycle answer, data only with ack
	a_ack_after_req: assert property (
		req && !ack_o |=> ack_o)
		else $error("request not acknowledged next cycle");

	a_ack_needs_req: assert property (
		ack_o |-> $past(req))
		else $error("ack without a request");

	a_idle_data_zero: assert property (
		!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");

	a_write_data_zero: assert property (
		ack_o && we_i |-> dat_o == 32'h0)
		else $error("data returned on a write");

	// Read paths mirror the stored state, reserved bits read zero
	a_scale_upper_zero: assert property (
		ack_o && !we_i && hit_scale |-> dat_o[7:6] == 2'b00)
		else $error("reserved scale bits not zero");

	a_scale_read_back: assert property (
		ack_o && !we_i && hit_scale |-> dat_o[5:0] == scale_reg[ch])
		else $error("scale read does not match register");

	a_ctrl_read_back: assert property (
		ack_o && !we_i && hit_ctrl |-> dat_o[6:0] == ctrl_reg[ch])
		else $error("control read does not match register");

	a_sample_read_back: assert property (
		ack_o && !we_i && hit_samp && !$past(rd_mode) |-> dat_o[6:0] == sample_reg[ch])
		else $error("sample read does not match held value");

	a_ram_read_range: assert property (
		ack_o && !we_i && hit_samp && $past(rd_mode) && !$past(rd_ok) |-> dat_o == 32'h0)
		else $error("reserved template address read not zero");

	a_unmapped_read: assert property (
		ack_o && !blk_ok |-> dat_o == 32'h0)
		else $error("unmapped read not zero");

	a_ch_map: assert property (
		blk_ok && !is_ch0 |-> ch != 4'h0)
		else $error("numbered block mapped onto channel 0");

	// Writes land only on a mapped, byte-enabled ack edge
	a_unmapped_write: assert property (
		req && we_i && !blk_ok |=> $stable(scale_reg[0]) && $stable(ctrl_reg[0]) && $stable(sample_reg[0]))
		else $error("unmapped write changed channel 0");

	a_sel_gate_write: assert property (
		req && we_i && !sel_i[0] |=> $stable(scale_reg[0]) && $stable(ctrl_reg[0]) && $stable(sample_reg[0]))
		else $error("write without byte enable landed");

	a_ctrl_write_hold: assert property (
		wr_fire && hit_ctrl && ch == 4'h0 |=> ctrl_reg[0] == $past(dat_i[6:0]))
		else $error("channel 0 control write lost");

	a_sample_write_hold: assert property (
		wr_fire && hit_samp && ch == 4'h0 |=> sample_reg[0] == $past(dat_i[6:0]))
		else $error("channel 0 sample write lost");

	a_ctrl_reset_val: assert property (
		disable iff (1'b0) !resetn_i |=> ctrl_reg[0] == 7'h00)
		else $error("control register not at reset value");

	a_sample_reset_val: assert property (
		disable iff (1'b0) !resetn_i |=> sample_reg[0] == 7'h00)
		else $error("sample register not at reset value");

	// Gain model checked on channel 0 around nominal and at the ends
	a_gain_reset_val: assert property (
		disable iff (1'b0) !resetn_i |=> amplitude_gain_o[7:0] == 8'h00)
		else $error("gain not cleared by reset");

	a_gain_follow: assert property (
		1'b1 |=> amplitude_gain_o[7:0] == $past(gain_next[0]))
		else $error("gain output lags more than one cycle");

	a_t1_step_up: assert property (
		!e1_mode_i[0] && scale_reg[0] == 6'h37 |-> gain_next[0] == 8'h66)
		else $error("T1 step up not plus 2 percent");

	a_t1_step_down: assert property (
		!e1_mode_i[0] && scale_reg[0] == 6'h35 |-> gain_next[0] == 8'h62)
		else $error("T1 step down not minus 2 percent");

	a_e1_step_up: assert property (
		e1_mode_i[0] && scale_reg[0] == 6'h22 |-> gain_next[0] == 8'h67)
		else $error("E1 step up not plus 3 percent");

	a_e1_step_down: assert property (
		e1_mode_i[0] && scale_reg[0] == 6'h20 |-> gain_next[0] == 8'h61)
		else $error("E1 step down not minus 3 percent");

	a_t1_top_code: assert property (
		!e1_mode_i[0] && scale_reg[0] == 6'h3f |-> gain_next[0] == 8'h76)
		else $error("T1 top code gain wrong");

	a_t1_floor: assert property (
		!e1_mode_i[0] && scale_reg[0] <= 6'h04 |-> gain_next[0] == 8'h00)
		else $error("T1 low codes not silenced");

	a_e1_floor: assert property (
		e1_mode_i[0] && scale_reg[0] == 6'h00 |-> gain_next[0] == 8'h01)
		else $error("E1 bottom code gain wrong");

	// Template RAM stores only on an armed write-direction control write
	a_tram_dir_write: assert property (
		wr_fire && hit_ctrl && dat_i[`TWS_CTRL_DIR] |-> !tram_wr)
		else $error("read direction stored into the RAM");

	a_tram_no_arb: assert property (
		wr_fire && hit_ctrl && !arb_mode |-> !tram_wr)
		else $error("RAM stored outside arbitrary mode");

	a_tram_one_shot: assert property (
		tram_wr |=> !tram_wr)
		else $error("template store repeated");

	a_tpl_port_range: assert property (
		tpl_rd_addr_i > 5'h12 |=> tpl_rd_data_o == 7'h00)
		else $error("reserved template readout not zero");


	c_scale_write:  cover property (wr_fire && hit_scale);
	c_tram_write:   cover property (tram_wr);
	c_tram_readout: cover property (ack_o && rd_mode && hit_samp);
	c_e1_nominal:   cover property (e1_mode_i[0] && scale_reg[0] == 6'h21);
	c_unmapped:     cover property (ack_o && !blk_ok);
endmodule

// File: sim/tws_regs_tb.sv
// Self-checking bench for the transmit scale and template register block
`timescale 1ns/1ps
module tws_regs_tb;
	import tws_pkg::*;
	logic        mclk_i = 1'b0, resetn_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [12:0] adr_i = 13'h0;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic        ack_o;
	logic [63:0] pulse_template_select_i = 64'h0;
	logic [15:0] e1_mode_i = 16'h0;
	logic [95:0] amplitude_factor_o;
	logic [127:0] amplitude_gain_o;
	logic [3:0]  tpl_rd_ch_i = 4'h0;
	tws_taddr_t  tpl_rd_addr_i = 5'h0;
	tws_sample_t tpl_rd_data_o;
	int          n_fail = 0, checks = 0;
	int          ram [16][19];
	always #2.5 mclk_i = ~mclk_i;
	tws_regs tws_regs_i (.mclk_i, .resetn_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.pulse_template_select_i, .e1_mode_i, .amplitude_factor_o, .amplitude_gain_o,
		.tpl_rd_ch_i, .tpl_rd_addr_i, .tpl_rd_data_o);
	function automatic logic [12:0] ra(int ch, int off);
		return 13'(((ch == 0) ? 32'h7c0 + off : (ch - 1) * 32'h40 + off) * 4);
	endfunction
	// Gain in percent of nominal, negative results clamp to silence
	function automatic int gain(int code, logic e1);
		int g;
		g = e1 ? 100 + 3 * (code - 33) : 100 + 2 * (code - 54);
		if (g < 0)
			g = 0;
		return g;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle; ack is sampled at the edge, before the slave updates
	task automatic wb(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [31:0] q);
		int t;
		@(posedge mclk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		t = 0;
		do begin
			@(posedge mclk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		chk(32'(t), 32'h2);
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h9e58));
		foreach (ram[c, a])
			ram[c][a] = -1;
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			wb(1'b0, ra(c, 7), 8'h0, rd);
			chk(rd, 32'h36);
			wb(1'b0, ra(c, 8), 8'h0, rd);
			chk(rd, 32'h0);
			wb(1'b0, ra(c, 9), 8'h0, rd);
			chk(rd, 32'h0);
		end
		e1_mode_i <= 16'hffff;
		for (int c = 0; c < 16; c++) begin
			wb(1'b1, ra(c, 7), 8'h21, rd);
			wb(1'b0, ra(c, 7), 8'h0, rd);
			chk(rd, 32'h21);
			chk(32'(amplitude_gain_o[c * 8 +: 8]), 32'(gain(33, 1'b1)));
		end
		for (int i = 0; i < 40; i++) begin
			int c, v;
			c = $urandom_range(15);
			v = (i < 8) ? (i % 4) * 32'h15 : $urandom_range(255);
			e1_mode_i <= (i < 8) ? {16{i[2]}} : 16'($urandom);
			wb(1'b1, ra(c, 7), v[7:0], rd);
			wb(1'b0, ra(c, 7), 8'h0, rd);
			chk(rd, 32'(v & 32'h3f));
			chk(32'(amplitude_factor_o[c * 6 +: 6]), 32'(v & 32'h3f));
			chk(32'(amplitude_gain_o[c * 8 +: 8]), 32'(gain(v & 32'h3f, e1_mode_i[c])));
		end
		for (int i = 0; i < 60; i++) begin
			int c, a, d, b;
			logic arb;
			logic [63:0] ps;
			c = $urandom_range(15);
			a = $urandom_range(21);
			d = $urandom_range(127);
			b = $urandom_range(18);
			arb = ($urandom_range(3) != 0);
			ps = {32'($urandom), 32'($urandom)};
			ps[c * 4 + 3] = arb;
			pulse_template_select_i <= ps;
			tpl_rd_ch_i <= c[3:0];
			tpl_rd_addr_i <= b[4:0];
			wb(1'b1, ra(c, 9), d[7:0], rd);
			wb(1'b1, ra(c, 8), 8'h40 | a[7:0], rd);
			if (arb && a < 19)
				ram[c][a] = d;
			wb(1'b0, ra(c, 9), 8'h0, rd);
			chk(rd, 32'(d));
			wb(1'b1, ra(c, 8), 8'h60 | a[7:0], rd);
			wb(1'b0, ra(c, 8), 8'h0, rd);
			chk(rd, 32'(8'h60 | a[7:0]));
			wb(1'b0, ra(c, 9), 8'h0, rd);
			chk(rd, 32'(!arb ? d : (a < 19) ? ram[c][a] : 0));
			if (ram[c][b] >= 0)
				chk(32'(tpl_rd_data_o), 32'(ram[c][b]));
		end
		wb(1'b1, ra(16, 7), 8'h2a, rd);
		wb(1'b0, ra(16, 7), 8'h0, rd);
		chk(rd, 32'h0);
		wrap_up();
	end
endmodule
